// [bench/cfp_assertions.sv]
// Purpose: port assertions of the programmer
// Assumes: bound to every cfp_programmer
// Notes: pin effects lag the pins by three clocks
`timescale 1ns/1ps
`default_nettype none
`include "cfp_defs.svh"
module cfp_checker
  import cfp_pkg::*;
#(
  parameter int PROG_PULSE_CYC = `CFP_PROG_PULSE_CYC
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic modeStepPin,
  input wire logic pushbuttonDataPin,
  input wire logic inTestMode,
  input wire logic [4:0] modeStep,
  input wire logic [4:0] senseLevelOut,
  input wire logic senseSwitchClose,
  input wire logic smokeCompEnable,
  input wire logic diagnosticOut,
  input wire cfp_nvm_wr_t nvmWrite,
  input wire logic [`CFP_CAL_BITS-1:0] activeCalWord,
  input wire cfp_features_t features
);
  logic calMode;
  assign calMode = inTestMode && (modeStep inside {[5'h04:5'h07]});
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  a_switch_comp_pair: assert property (senseSwitchClose == smokeCompEnable)
    else $error("switch and comparator enable differ");
  a_switch_data_low: assert property (senseSwitchClose ==
      ($past(calMode) && !$past(pushbuttonDataPin, 3)))
    else $error("sense switch not following the data pin");
  a_switch_in_cal: assert property (senseSwitchClose |-> $past(calMode))
    else $error("sense switch closed outside a calibration mode");
  a_level_gated: assert property (senseLevelOut != 5'h00 |-> senseSwitchClose)
    else $error("sense level shown with switch open");
  a_diag_idle: assert property (!calMode && !$past(calMode) |-> !diagnosticOut)
    else $error("diagnostic output active outside calibration");
  a_normal_zero: assert property (!inTestMode |-> modeStep == 5'h00)
    else $error("mode number not zero in normal operation");
  a_req_single: assert property (nvmWrite.req |=> !nvmWrite.req)
    else $error("memory write request longer than one cycle");
  a_write_mode: assert property (nvmWrite.req |-> !nvmWrite.data[`CFP_FEAT_UNUSED] &&
      (nvmWrite.isFeature ? modeStep == 5'h02 : modeStep inside {5'h08, 5'h0a}))
    else $error("memory write in the wrong mode");
  a_step_by_one: assert property (inTestMode && $past(inTestMode) &&
      modeStep != $past(modeStep) |-> modeStep == $past(modeStep) + 5'h01)
    else $error("mode advanced by other than one");
  a_quiet_exit: assert property ((!modeStepPin && !pushbuttonDataPin) [*5] |=> !inTestMode)
    else $error("test mode kept with step and data low");
  a_active_held: assert property ($past(rst_n, 2) |-> $stable(activeCalWord) && $stable(features))
    else $error("active settings changed without reset");
endmodule // cfp_checker

bind cfp_programmer cfp_checker #(.PROG_PULSE_CYC(PROG_PULSE_CYC)) chk_u (.clock(clock),
  .rst_n(rst_n), .modeStepPin(modeStepPin), .pushbuttonDataPin(pushbuttonDataPin),
  .inTestMode(inTestMode), .modeStep(modeStep), .senseLevelOut(senseLevelOut),
  .senseSwitchClose(senseSwitchClose), .smokeCompEnable(smokeCompEnable),
  .diagnosticOut(diagnosticOut), .nvmWrite(nvmWrite), .activeCalWord(activeCalWord),
  .features(features));
`default_nettype wire

// [bench/cfp_fixture.sv]
// Purpose: programming fixture model driving the test pins
// Assumes: pins change just after falling clock edges
// Notes: link half period is 4 clocks
`timescale 1ns/1ps
`default_nettype none
module cfp_fixture (
  input wire logic clock,
  output logic modeStepPin,
  output logic pushbuttonDataPin,
  output logic shiftClkPin,
  output logic interconnectPin,
  output logic smokeComparatorResult
);
  initial begin
    {modeStepPin, pushbuttonDataPin, shiftClkPin, interconnectPin} = 4'h0;
    smokeComparatorResult = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic pulse();
    modeStepPin = 1'b0;
    wt(4);
    modeStepPin = 1'b1;
    wt(6);
  endtask
  task automatic enter(input int n);
    modeStepPin = 1'b1;
    wt(4);
    pushbuttonDataPin = 1'b1;
    wt(4);
    repeat (n) pulse();
  endtask
  task automatic drive(input logic d, input logic c);
    pushbuttonDataPin = d;
    smokeComparatorResult = c;
    wt(6);
  endtask
  task automatic leave();
    pushbuttonDataPin = 1'b0;
    modeStepPin = 1'b0;
    wt(8);
  endtask
  // one bit per shift clock, lsb first
  task automatic shift(input logic [17:0] w, input int n);
    for (int i = 0; i < n; i++) begin
      pushbuttonDataPin = w[i];
      wt(4);
      shiftClkPin = 1'b1;
      wt(4);
      shiftClkPin = 1'b0;
    end
    wt(4);
  endtask
  task automatic icPulse(input int hi);
    interconnectPin = 1'b1;
    wt(hi);
    interconnectPin = 1'b0;
    wt(8);
  endtask
endmodule // cfp_fixture
`default_nettype wire

// [bench/tb_top.sv]
// Purpose: self-checking bench of the programmer
// Assumes: fixture model drives all pins
// Notes: commit pulse shortened to 20 clocks
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import cfp_pkg::*;
;
  localparam logic [16:0] CAL0 = {5'h1b, 4'hd, 3'h6, 5'h1e};
  localparam logic [16:0] SER = 17'h0a5c3;
  localparam logic [17:0] FEAT0 = 18'h14a5c;
  localparam logic [17:0] FEATW = 18'h2b893;
  logic clock, rst_n, modeStepPin, pushbuttonDataPin, shiftClkPin, interconnectPin;
  logic smokeComparatorResult, inTestMode, senseSwitchClose, smokeCompEnable, diagnosticOut;
  logic [16:0] nvmCal, activeCalWord;
  logic [17:0] nvmFeat;
  logic [4:0] modeStep, senseLevelOut;
  cfp_nvm_wr_t nvmWrite, wrLast;
  cfp_features_t features;
  int failCount = 0, checks = 0, wrCnt = 0, cycles = 0, n0;
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  cfp_programmer #(.PROG_PULSE_CYC(20)) dut_u (.clock, .rst_n, .modeStepPin, .pushbuttonDataPin,
    .shiftClkPin, .interconnectPin, .smokeComparatorResult, .nvmCalStored(nvmCal),
    .nvmFeatStored(nvmFeat), .inTestMode, .modeStep, .senseLevelOut, .senseSwitchClose,
    .smokeCompEnable, .diagnosticOut, .nvmWrite, .activeCalWord, .features);
  cfp_fixture fx_u (.clock, .modeStepPin, .pushbuttonDataPin, .shiftClkPin, .interconnectPin,
    .smokeComparatorResult);
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (nvmWrite.req === 1'b1) begin
      wrCnt <= wrCnt + 1;
      wrLast <= nvmWrite;
    end
  end
  always @(negedge clock) if (cycles == 20000) begin
    failCount++;
    give_verdict();
  end
  function automatic cfp_features_t expFeat(input logic [17:0] f);
    return {f[16:15], f[14], f[13], f[12], f[11], f[0]};
  endfunction
  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    checks++;
    if (got !== exp) begin
      failCount++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, failCount);
    if (failCount == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic testCal();
    logic [16:0] exp;
    logic [4:0] fld;
    int lsb[4] = '{0, 5, 8, 12};
    logic [4:0] msk[4] = '{5'h1f, 5'h07, 5'h0f, 5'h1f};
    exp = CAL0;
    fx_u.enter(4);
    for (int m = 0; m < 4; m++) begin
      if (m > 0) fx_u.pulse();
      fld = 5'(exp >> lsb[m]) & msk[m];
      chk(modeStep, 5'h04 + 5'(m));
      fx_u.drive(1'b0, 1'b1);
      chk({senseSwitchClose, smokeCompEnable, diagnosticOut}, 3'h7);
      chk(senseLevelOut, fld);
      fx_u.shift(18'h0, 3);
      fld = (fld + 5'h03) & msk[m];
      chk(senseLevelOut, fld);
      fx_u.icPulse(4);
      exp = (exp & ~(17'(msk[m]) << lsb[m])) | (17'(fld) << lsb[m]);
      fx_u.drive(1'b1, 1'b0);
      chk({senseSwitchClose, smokeCompEnable, diagnosticOut}, 3'h0);
    end
    fx_u.pulse();
    chk(modeStep, 5'h08);
    chk(wrCnt, 0);
    n0 = wrCnt;
    fx_u.icPulse(4);
    chk(wrCnt - n0, 1);
    chk(wrLast.isFeature, 0);
    chk(wrLast.data, {1'b0, exp});
    chk(activeCalWord, CAL0);
    fx_u.leave();
    chk(inTestMode, 0);
    $display("calibration test done");
  endtask
  task automatic testSerial();
    fx_u.enter(10);
    chk(modeStep, 5'h0a);
    n0 = wrCnt;
    fx_u.shift({1'b0, SER}, 17);
    fx_u.icPulse(4);
    chk(wrCnt - n0, 1);
    chk(wrLast.data, {1'b0, SER});
    fx_u.leave();
    $display("serial test done");
  endtask
  task automatic testFeature();
    fx_u.enter(2);
    chk(modeStep, 5'h02);
    n0 = wrCnt;
    fx_u.shift(FEATW, 18);
    fx_u.icPulse(8);
    chk(wrCnt - n0, 0);
    fx_u.icPulse(40);
    chk(wrCnt - n0, 1);
    chk(wrLast.isFeature, 1);
    chk(wrLast.data, {1'b0, FEATW[16:0]});
    chk(features, expFeat(FEAT0));
    fx_u.leave();
    $display("feature test done");
  endtask
  initial begin
    rst_n = 1'b0;
    nvmCal = CAL0;
    nvmFeat = FEAT0;
    repeat (2) @(negedge clock);
    rst_n = 1'b1;
    fx_u.wt(3);
    chk(inTestMode, 0);
    chk(activeCalWord, CAL0);
    chk(features, expFeat(FEAT0));
    fx_u.enter(0);
    chk({inTestMode, modeStep}, 6'h20);
    fx_u.leave();
    chk(inTestMode, 0);
    testCal();
    testSerial();
    testFeature();
    rst_n = 1'b0;
    nvmCal = SER;
    nvmFeat = FEATW;
    fx_u.wt(2);
    rst_n = 1'b1;
    fx_u.wt(3);
    chk(activeCalWord, SER);
    chk(features, expFeat(FEATW));
    $display("power cycle test done");
    give_verdict();
  end
endmodule // tb_top
`default_nettype wire

// [core/cfp_defs.svh]
// Purpose: constants of the calibration and feature programmer
// Assumes: included by the package and the programmer module
// Notes: bit positions are zero based; word bit 1 sits at index 0
`ifndef CFP_DEFS_SVH
`define CFP_DEFS_SVH

// synchronised pin vector positions
`define CFP_PIN_STEP 0
`define CFP_PIN_DATA 1
`define CFP_PIN_SHCLK 2
`define CFP_PIN_IC 3
`define CFP_PIN_CMP 4
`define CFP_PIN_W 5

// mode step counts after the speedup mode
`define CFP_TM_FEATURE 5'h02
`define CFP_TM_STANDBY 5'h04
`define CFP_TM_HYST 5'h05
`define CFP_TM_QUIET 5'h06
`define CFP_TM_CHAMBER 5'h07
`define CFP_TM_COMMIT 5'h08
`define CFP_TM_SERIAL 5'h0a
`define CFP_TM_LAST 5'h13

// calibration word layout
`define CFP_CAL_BITS 17
`define CFP_CAL_BITS_C 5'h11
`define CFP_CAL_STBY_LSB 0
`define CFP_CAL_HYST_LSB 5
`define CFP_CAL_QUIET_LSB 8
`define CFP_CAL_CHAM_LSB 12
`define CFP_MASK_W5 5'h1f
`define CFP_MASK_W4 5'h0f
`define CFP_MASK_W3 5'h07

// feature word layout
`define CFP_FEAT_BITS 18
`define CFP_FEAT_BITS_C 5'h12
`define CFP_FEAT_UNUSED 17
`define CFP_FEAT_LBT_LSB 15
`define CFP_FEAT_EOL 14
`define CFP_FEAT_CO 13
`define CFP_FEAT_AUTO_LOCATE_DISABLE 12
`define CFP_FEAT_SYNC 11
`define CFP_FEAT_TONE_PATTERN_SEL 0

// commit pulse timing
`define CFP_CLK_HZ 40000000
`define CFP_PROG_PULSE_MS 10
`define CFP_PROG_PULSE_CYC ((`CFP_PROG_PULSE_MS * `CFP_CLK_HZ + 999) / 1000)
`define CFP_HOLD_CNT_W 20

// reset values
`define CFP_RST_STEP 5'h00
`define CFP_RST_LEVEL 5'h00

`endif

// [core/cfp_pkg.sv]
// Purpose: types of the calibration and feature programmer
// Assumes: cfp_defs.svh on the include path
// Notes: state of the programmer is one packed struct
`include "cfp_defs.svh"

package cfp_pkg;

  typedef enum logic [0:0] {
    CFP_PH_NORMAL = 1'b0,
    CFP_PH_TEST = 1'b1
  } cfp_phase_t;

  typedef struct packed {
    logic [1:0] lowBatteryTripSel;
    logic endOfLifeEnable;
    logic coSignalEnable;
    logic autoLocateDisable;
    logic hornSyncEnable;
    logic tonePatternSel;
  } cfp_features_t;

  typedef struct packed {
    logic req;
    logic isFeature;
    logic [`CFP_FEAT_BITS-1:0] data;
  } cfp_nvm_wr_t;

  typedef struct packed {
    logic [`CFP_PIN_W-1:0] sync1;
    logic [`CFP_PIN_W-1:0] sync2;
    logic [`CFP_PIN_W-2:0] prev;
    logic loaded;
    cfp_phase_t phase;
    logic [4:0] step;
    logic [4:0] level;
    logic [`CFP_CAL_BITS-1:0] calPend;
    logic [`CFP_CAL_BITS-1:0] activeCal;
    logic [`CFP_FEAT_BITS-1:0] activeFeat;
    logic [`CFP_FEAT_BITS-1:0] shiftWord;
    logic [4:0] bitCount;
    logic [`CFP_HOLD_CNT_W-1:0] icHighCnt;
    cfp_nvm_wr_t nvm;
    logic [4:0] senseOut;
    logic switchOn;
    logic compEn;
    logic diag;
  } cfp_state_t;

endpackage

// [core/cfp_programmer.sv]
// Purpose: test-mode calibration and feature programming logic
// Assumes: pins arrive asynchronously; nvm words are valid at reset release
// Notes: stored words take effect only at the next reset
//
// What this block does
// - four calibration modes, each own trim
// - cal modes drive sense level, comparator out
// - shift clock steps level, interconnect latches
// - power up into normal operation mode
// - step pulses with data high advance mode
// - data low enables comparator, closes switch
// - next pulses: hysteresis, quiet, chamber cal
// - commit mode writes latched trims to nvm
// - ten step pulses enter serial cal
// - serial modes: data pin, shift clock
// - seventeen bits then interconnect pulse stores
// - calibration word field positions fixed
// - two step pulses enter feature mode
// - interconnect pulse of 10 ms commits features
// - bit 15 end of life enable
// - bit 14 co signal enable
// - bit 13 disables auto locate
// - bit 12 horn sync enable
// - step and data low return normal
// - step counted on rising mode-step edge
// - bit 1 selects tone pattern
`timescale 1ns/1ps
`default_nettype none
`include "cfp_defs.svh"

module cfp_programmer
  import cfp_pkg::*;
#(
  parameter int PROG_PULSE_CYC = `CFP_PROG_PULSE_CYC
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic modeStepPin,
  input wire logic pushbuttonDataPin,
  input wire logic shiftClkPin,
  input wire logic interconnectPin,
  input wire logic smokeComparatorResult,
  input wire logic [`CFP_CAL_BITS-1:0] nvmCalStored,
  input wire logic [`CFP_FEAT_BITS-1:0] nvmFeatStored,
  output logic inTestMode,
  output logic [4:0] modeStep,
  output logic [4:0] senseLevelOut,
  output logic senseSwitchClose,
  output logic smokeCompEnable,
  output logic diagnosticOut,
  output cfp_nvm_wr_t nvmWrite,
  output logic [`CFP_CAL_BITS-1:0] activeCalWord,
  output cfp_features_t features
);

  localparam logic [`CFP_HOLD_CNT_W-1:0] HOLD_LIMIT = `CFP_HOLD_CNT_W'(PROG_PULSE_CYC);

  cfp_state_t state_ff;
  cfp_state_t nxt_state;

  // width mask of the trim owned by a calibration mode
  function automatic logic [4:0] trimMask(input logic [4:0] step);
    logic [4:0] m;
    m = `CFP_MASK_W5;
    if (step == `CFP_TM_HYST) begin
      m = `CFP_MASK_W3;
    end else if (step == `CFP_TM_QUIET) begin
      m = `CFP_MASK_W4;
    end
    return m;
  endfunction

  // trim of a calibration mode taken from a calibration word
  function automatic logic [4:0] trimOf(input logic [`CFP_CAL_BITS-1:0] w,
                                        input logic [4:0] step);
    logic [4:0] t;
    t = w[`CFP_CAL_STBY_LSB +: 5];
    if (step == `CFP_TM_HYST) begin
      t = {2'b00, w[`CFP_CAL_HYST_LSB +: 3]};
    end else if (step == `CFP_TM_QUIET) begin
      t = {1'b0, w[`CFP_CAL_QUIET_LSB +: 4]};
    end else if (step == `CFP_TM_CHAMBER) begin
      t = w[`CFP_CAL_CHAM_LSB +: 5];
    end
    return t;
  endfunction

  function automatic logic isCalMode(input logic [4:0] step);
    return (step >= `CFP_TM_STANDBY) && (step <= `CFP_TM_CHAMBER);
  endfunction

  always_comb begin
    logic stepLvl;
    logic dataLvl;
    logic stepRise;
    logic shRise;
    logic icRise;
    logic icFall;
    logic calMode;
    logic serialMode;
    logic [4:0] nextStep;
    stepLvl = state_ff.sync2[`CFP_PIN_STEP];
    dataLvl = state_ff.sync2[`CFP_PIN_DATA];
    stepRise = stepLvl & ~state_ff.prev[`CFP_PIN_STEP];
    shRise = state_ff.sync2[`CFP_PIN_SHCLK] & ~state_ff.prev[`CFP_PIN_SHCLK];
    icRise = state_ff.sync2[`CFP_PIN_IC] & ~state_ff.prev[`CFP_PIN_IC];
    icFall = ~state_ff.sync2[`CFP_PIN_IC] & state_ff.prev[`CFP_PIN_IC];
    calMode = (state_ff.phase == CFP_PH_TEST) && isCalMode(state_ff.step);
    serialMode = (state_ff.phase == CFP_PH_TEST) &&
                 ((state_ff.step == `CFP_TM_SERIAL) || (state_ff.step == `CFP_TM_FEATURE));
    nextStep = state_ff.step;

    nxt_state = state_ff;
    nxt_state.sync1 = {smokeComparatorResult, interconnectPin, shiftClkPin,
                       pushbuttonDataPin, modeStepPin};
    nxt_state.sync2 = state_ff.sync1;
    nxt_state.prev = state_ff.sync2[`CFP_PIN_W-2:0];
    nxt_state.nvm.req = 1'b0;

    // stored words become active only after reset
    if (!state_ff.loaded) begin
      nxt_state.loaded = 1'b1;
      nxt_state.activeCal = nvmCalStored;
      nxt_state.activeFeat = nvmFeatStored;
      nxt_state.calPend = nvmCalStored;
    end

    unique case (state_ff.phase)
      CFP_PH_NORMAL: begin
        // leave normal mode on first step rise
        if (stepRise) begin
          nxt_state.phase = CFP_PH_TEST;
          nxt_state.step = `CFP_RST_STEP;
          nxt_state.bitCount = 5'h00;
          nxt_state.icHighCnt = '0;
        end
      end
      CFP_PH_TEST: begin
        if (!stepLvl && !dataLvl) begin
          nxt_state.phase = CFP_PH_NORMAL;
          nxt_state.step = `CFP_RST_STEP;
        end else if (stepRise && dataLvl) begin
          if (state_ff.step != `CFP_TM_LAST) begin
            nextStep = state_ff.step + 5'h01;
          end
          nxt_state.step = nextStep;
          nxt_state.level = trimOf(state_ff.calPend, nextStep);
          nxt_state.bitCount = 5'h00;
          nxt_state.shiftWord = '0;
          nxt_state.icHighCnt = '0;
        end else begin
          if (calMode && shRise) begin
            nxt_state.level = (state_ff.level + 5'h01) & trimMask(state_ff.step);
          end
          if (calMode && icRise) begin
            unique case (state_ff.step)
              `CFP_TM_STANDBY: begin
                nxt_state.calPend[`CFP_CAL_STBY_LSB +: 5] = state_ff.level;
              end
              `CFP_TM_HYST: begin
                nxt_state.calPend[`CFP_CAL_HYST_LSB +: 3] = state_ff.level[2:0];
              end
              `CFP_TM_QUIET: begin
                nxt_state.calPend[`CFP_CAL_QUIET_LSB +: 4] = state_ff.level[3:0];
              end
              default: begin
                nxt_state.calPend[`CFP_CAL_CHAM_LSB +: 5] = state_ff.level;
              end
            endcase
          end
          if (state_ff.step == `CFP_TM_COMMIT && icRise) begin
            nxt_state.nvm.req = 1'b1;
            nxt_state.nvm.isFeature = 1'b0;
            nxt_state.nvm.data = {1'b0, state_ff.calPend};
          end
          if (serialMode && shRise) begin
            if ((state_ff.step == `CFP_TM_SERIAL && state_ff.bitCount < `CFP_CAL_BITS_C) ||
                (state_ff.step == `CFP_TM_FEATURE &&
                 state_ff.bitCount < `CFP_FEAT_BITS_C)) begin
              // first bit lands in bit 1
              nxt_state.shiftWord[state_ff.bitCount] = dataLvl;
              nxt_state.bitCount = state_ff.bitCount + 5'h01;
            end
          end
          if (state_ff.step == `CFP_TM_SERIAL && icRise &&
              state_ff.bitCount == `CFP_CAL_BITS_C) begin
            nxt_state.nvm.req = 1'b1;
            nxt_state.nvm.isFeature = 1'b0;
            nxt_state.nvm.data = {1'b0, state_ff.shiftWord[`CFP_CAL_BITS-1:0]};
          end
          if (state_ff.step == `CFP_TM_FEATURE) begin
            if (state_ff.sync2[`CFP_PIN_IC] && state_ff.icHighCnt != '1) begin
              nxt_state.icHighCnt = state_ff.icHighCnt + `CFP_HOLD_CNT_W'(1);
            end
            if (icFall) begin
              nxt_state.icHighCnt = '0;
              if (state_ff.icHighCnt >= HOLD_LIMIT &&
                  state_ff.bitCount == `CFP_FEAT_BITS_C) begin
                nxt_state.nvm.req = 1'b1;
                nxt_state.nvm.isFeature = 1'b1;
                nxt_state.nvm.data = state_ff.shiftWord;
                nxt_state.nvm.data[`CFP_FEAT_UNUSED] = 1'b0;
              end
            end
          end
        end
      end
    endcase

    // data low enables comparator and switch
    nxt_state.compEn = calMode && !dataLvl;
    nxt_state.switchOn = calMode && !dataLvl;
    nxt_state.senseOut = (calMode && !dataLvl) ? nxt_state.level : `CFP_RST_LEVEL;
    nxt_state.diag = calMode && state_ff.sync2[`CFP_PIN_CMP];
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign inTestMode = (state_ff.phase == CFP_PH_TEST);
  assign modeStep = state_ff.step;
  assign senseLevelOut = state_ff.senseOut;
  assign senseSwitchClose = state_ff.switchOn;
  assign smokeCompEnable = state_ff.compEn;
  assign diagnosticOut = state_ff.diag;
  assign nvmWrite = state_ff.nvm;
  assign activeCalWord = state_ff.activeCal;

  // battery trip select from bits 17-16
  assign features.lowBatteryTripSel = state_ff.activeFeat[`CFP_FEAT_LBT_LSB +: 2];
  assign features.endOfLifeEnable = state_ff.activeFeat[`CFP_FEAT_EOL];
  assign features.coSignalEnable = state_ff.activeFeat[`CFP_FEAT_CO];
  assign features.autoLocateDisable = state_ff.activeFeat[`CFP_FEAT_AUTO_LOCATE_DISABLE];
  assign features.hornSyncEnable = state_ff.activeFeat[`CFP_FEAT_SYNC];
  assign features.tonePatternSel = state_ff.activeFeat[`CFP_FEAT_TONE_PATTERN_SEL];

endmodule // cfp_programmer

`default_nettype wire
